// [mcr_bank.v]
/*
 Register front end of the hardware monitor: location pointer, control and
 status registers, value RAM, interrupt line, reset pulse, intrusion clear
 and general output.
 Assumes a serial bus slave outside turns bus frames into one-cycle strobes
 synchronous to sys_clk, and that the monitoring loop reports events as
 one-cycle set pulses.
*/
// Operation
// - An 8-bit pointer selects the accessed location; zero after power-on.
// - Pointer decode: 00h-06h control registers, 20h-3Fh value RAM.
// - Config bit 0 one runs the scan; zero means standby.
// - Clearing bit 0 leaves an asserted interrupt output asserted.
// - Config bit 1 enables the interrupt line; zero keeps it inactive.
// - Config bit 2 picks polarity: high open-source or low open-drain.
// - Config bit 3 releases interrupt and reset pins; status untouched.
// - While config bit 3 is one the scan halts.
// - When config bit 3 returns to zero the scan resumes.
// - Config bit 4 pulses reset pin low 10 ms when enabled.
// - Config bit 4 clears itself once the reset pulse ends.
// - Config bit 5 clears the external intrusion latch via its pin.
// - Config bit 5 clears itself when the intrusion clear completes.
// - General output pin follows config bit 6.
// - Writing one to config bit 7 reloads power-on values of 00h-06h.
// - Config bit 7 reads back zero after the restore.
// - Reading a status register returns then clears it, dropping interrupt.
// - Intrusion clear drives its line low for at least 10 ms.
`timescale 1ns/1ps
`include "mcr_consts.vh"
module mcr_bank #(
  parameter PULSE_CYCLES = `MCR_PULSE_CYC
) (
  input wire sys_clk,
  input wire arst_n,
  // Host access strobes from the serial bus slave
  input wire ptr_wr,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] host_wdata,
  output wire [7:0] host_rdata,
  output wire host_rvalid,
  // Monitoring loop
  input wire [7:0] stat1_set,
  input wire [7:0] stat2_set,
  input wire overtemp_active,
  output wire scan_run,
  output wire [7:0] fan_divider,
  output wire [7:0] overtemp_config,
  // Pins
  output wire irq_line_o,
  output wire irq_line_oe_n,
  output wire reset_or_overtemp_pin_o,
  output wire reset_or_overtemp_pin_oe_n,
  input wire intrusion_input_i,
  output wire intrusion_input_o,
  output wire intrusion_input_oe_n,
  output wire general_output,
  output wire intrusion_seen
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function is_ram;
    input [7:0] p;
    begin
      is_ram = (p >= `MCR_RAM_FIRST) && (p <= `MCR_RAM_LAST);
    end
  endfunction

  function [7:0] reg_read;
    input [7:0] p;
    input [7:0] cfg;
    input [7:0] s1;
    input [7:0] s2;
    input [7:0] m1;
    input [7:0] m2;
    input [7:0] fd;
    input [7:0] ot;
    begin
      case (p)
        `MCR_OFS_CFG: reg_read = cfg;
        `MCR_OFS_STAT1: reg_read = s1;
        `MCR_OFS_STAT2: reg_read = s2;
        `MCR_OFS_MASK1: reg_read = m1;
        `MCR_OFS_MASK2: reg_read = m2;
        `MCR_OFS_FANDIV: reg_read = fd;
        `MCR_OFS_OTCFG: reg_read = ot;
        default: reg_read = `MCR_UNMAPPED_READ;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [7:0] ptr_q;
  reg [7:0] cfg_q;
  reg [7:0] cfg_d;
  reg [7:0] stat1_q;
  reg [7:0] stat1_d;
  reg [7:0] stat2_q;
  reg [7:0] stat2_d;
  reg [7:0] mask1_q;
  reg [7:0] mask1_d;
  reg [7:0] mask2_q;
  reg [7:0] mask2_d;
  reg [7:0] fandiv_q;
  reg [7:0] fandiv_d;
  reg [7:0] otcfg_q;
  reg [7:0] otcfg_d;
  reg [7:0] rd_hold_q;
  reg rd_ram_q;
  reg rd_p1_q;
  reg [7:0] rdata_q;
  reg rvalid_q;
  reg irq_pend_q;

  wire [7:0] ram_rdata;
  wire ptr_in_ram;
  wire wr_cfg;
  wire restore;
  wire rst_done;
  wire rst_active;
  wire clr_done;
  wire clr_active;
  wire rst_func;
  wire os_func;
  wire rst_pin_low;
  wire irq_assert;
  wire [7:0] set1_g;
  wire [7:0] set2_g;
  wire rd_stat1;
  wire rd_stat2;

  assign ptr_in_ram = is_ram(ptr_q);
  assign wr_cfg = data_wr && (ptr_q == `MCR_OFS_CFG);
  assign restore = wr_cfg && host_wdata[`MCR_CFG_RESTORE];
  assign rd_stat1 = data_rd && (ptr_q == `MCR_OFS_STAT1);
  assign rd_stat2 = data_rd && (ptr_q == `MCR_OFS_STAT2);

  ////////////////////////////////////////////////////////////////////////////
  // Pointer

  // Held across transactions; only a pointer write moves it
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr_q <= `MCR_PTR_RESET;
    end
    else if (ptr_wr)
    begin
      ptr_q <= host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan control

  // Release bit freezes the loop without touching the start bit
  assign scan_run = cfg_q[`MCR_CFG_START] & ~cfg_q[`MCR_CFG_OUT_REL];
  assign set1_g = scan_run ? stat1_set : 8'h00;
  assign set2_g = scan_run ? (stat2_set & `MCR_STAT2_USED) : 8'h00;
  assign fan_divider = fandiv_q;
  assign overtemp_config = otcfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register next values

  always @*
  begin
    cfg_d = cfg_q;
    mask1_d = mask1_q;
    mask2_d = mask2_q;
    fandiv_d = fandiv_q;
    otcfg_d = otcfg_q;
    stat1_d = stat1_q;
    stat2_d = stat2_q;
    if (data_wr)
    begin
      case (ptr_q)
        `MCR_OFS_CFG: cfg_d = host_wdata;
        `MCR_OFS_MASK1: mask1_d = host_wdata;
        `MCR_OFS_MASK2: mask2_d = host_wdata;
        `MCR_OFS_FANDIV: fandiv_d = host_wdata;
        `MCR_OFS_OTCFG: otcfg_d = host_wdata;
        default: cfg_d = cfg_q;
      endcase
    end
    // Self-clearing commands end with their pulse
    if (rst_done && !(wr_cfg && host_wdata[`MCR_CFG_RST_PULSE]))
    begin
      cfg_d[`MCR_CFG_RST_PULSE] = 1'b0;
    end
    if (clr_done && !(wr_cfg && host_wdata[`MCR_CFG_INTR_CLR]))
    begin
      cfg_d[`MCR_CFG_INTR_CLR] = 1'b0;
    end
    if (rd_stat1)
    begin
      stat1_d = `MCR_STAT_RESET;
    end
    if (rd_stat2)
    begin
      stat2_d = `MCR_STAT_RESET;
    end
    if (restore)
    begin
      cfg_d = `MCR_CFG_RESET;
      stat1_d = `MCR_STAT_RESET;
      stat2_d = `MCR_STAT_RESET;
      mask1_d = `MCR_MASK_RESET;
      mask2_d = `MCR_MASK_RESET;
      fandiv_d = `MCR_FANDIV_RESET;
      otcfg_d = `MCR_OTCFG_RESET;
    end
    // A new event in the clearing cycle survives
    stat1_d = stat1_d | set1_g;
    stat2_d = stat2_d | set2_g;
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= `MCR_CFG_RESET;
      stat1_q <= `MCR_STAT_RESET;
      stat2_q <= `MCR_STAT_RESET;
      mask1_q <= `MCR_MASK_RESET;
      mask2_q <= `MCR_MASK_RESET;
      fandiv_q <= `MCR_FANDIV_RESET;
      otcfg_q <= `MCR_OTCFG_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
      stat1_q <= stat1_d;
      stat2_q <= stat2_d;
      mask1_q <= mask1_d;
      mask2_q <= mask2_d;
      fandiv_q <= fandiv_d;
      otcfg_q <= otcfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Two-stage read: RAM data is only valid a cycle after the strobe
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_hold_q <= 8'h00;
      rd_ram_q <= 1'b0;
      rd_p1_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rd_p1_q <= data_rd;
      rvalid_q <= rd_p1_q;
      if (data_rd)
      begin
        rd_hold_q <= reg_read(ptr_q, cfg_q, stat1_q, stat2_q, mask1_q, mask2_q, fandiv_q, otcfg_q);
        rd_ram_q <= ptr_in_ram;
      end
      if (rd_p1_q)
      begin
        rdata_q <= rd_ram_q ? ram_rdata : rd_hold_q;
      end
    end
  end

  assign host_rdata = rdata_q;
  assign host_rvalid = rvalid_q;

  mcr_value_ram #(
    .AW(`MCR_RAM_AW),
    .DEPTH(`MCR_RAM_DEPTH)
  ) u_ram (
    .sys_clk(sys_clk),
    .wr_en(data_wr & ptr_in_ram),
    .rd_en(data_rd & ptr_in_ram),
    .addr(ptr_q[`MCR_RAM_AW-1:0]),
    .wdata(host_wdata),
    .rdata_q(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line

  // Pending derives from status and masks only, so stopping the scan keeps it up
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_pend_q <= 1'b0;
    end
    else
    begin
      irq_pend_q <= |((stat1_d & ~mask1_d) | (stat2_d & ~mask2_d));
    end
  end

  assign irq_assert = irq_pend_q & cfg_q[`MCR_CFG_IRQ_EN] & ~cfg_q[`MCR_CFG_OUT_REL];
  // High: drive one when asserted; low: pull down when asserted; else float
  assign irq_line_o = cfg_q[`MCR_CFG_IRQ_POL];
  assign irq_line_oe_n = ~irq_assert;

  ////////////////////////////////////////////////////////////////////////////
  // Reset / overtemperature pin

  assign rst_func = fandiv_q[`MCR_FAN_RST_EN] & ~fandiv_q[`MCR_FAN_OS_EN];
  assign os_func = fandiv_q[`MCR_FAN_OS_EN] & ~fandiv_q[`MCR_FAN_RST_EN];

  mcr_pulse_timer #(
    .W(`MCR_TMR_W),
    .CYCLES(PULSE_CYCLES)
  ) u_rst_tmr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(cfg_q[`MCR_CFG_RST_PULSE]),
    .active(rst_active),
    .done(rst_done)
  );

  // Timer runs even when the pin is not in reset mode, so the bit still clears
  assign rst_pin_low = ((rst_func & rst_active) | (os_func & overtemp_active)) &
                       ~cfg_q[`MCR_CFG_OUT_REL];
  assign reset_or_overtemp_pin_o = 1'b0;
  assign reset_or_overtemp_pin_oe_n = ~rst_pin_low;

  ////////////////////////////////////////////////////////////////////////////
  // Intrusion latch clear

  mcr_pulse_timer #(
    .W(`MCR_TMR_W),
    .CYCLES(PULSE_CYCLES)
  ) u_clr_tmr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(cfg_q[`MCR_CFG_INTR_CLR]),
    .active(clr_active),
    .done(clr_done)
  );

  assign intrusion_input_o = 1'b0;
  assign intrusion_input_oe_n = ~clr_active;
  // Sense is meaningless while this end pulls the line down
  assign intrusion_seen = intrusion_input_i & ~clr_active;

  ////////////////////////////////////////////////////////////////////////////
  // General output

  assign general_output = cfg_q[`MCR_CFG_GPO];

endmodule

// [mcr_bank_chk.sv]
/* Port checker of the monitor register bank.
 Assumes binding to mcr_bank; tracks the pointer from the strobes. */
`timescale 1ns/1ps
module mcr_bank_chk #(
  parameter PULSE_CYCLES = 500000
) (
  input wire sys_clk,
  input wire arst_n,
  input wire ptr_wr,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] host_wdata,
  input wire [7:0] host_rdata,
  input wire host_rvalid,
  input wire scan_run,
  input wire [7:0] fan_divider,
  input wire [7:0] overtemp_config,
  input wire irq_line_o,
  input wire irq_line_oe_n,
  input wire reset_or_overtemp_pin_oe_n,
  input wire intrusion_input_oe_n,
  input wire general_output
);
  reg [7:0] ptr_q;
  reg pol_q;
  reg [31:0] rlow_q;
  reg [31:0] ilow_q;
  wire cfg_wr = data_wr && ptr_q == 8'h00;
  wire cw = cfg_wr && !host_wdata[7];
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ptr_q <= 8'h00;
      pol_q <= 1'b0;
      rlow_q <= 32'h0;
      ilow_q <= 32'h0;
    end
    else
    begin
      ptr_q <= ptr_wr ? host_wdata : ptr_q;
      pol_q <= cfg_wr ? cw & host_wdata[2] : pol_q;
      rlow_q <= reset_or_overtemp_pin_oe_n ? 32'h0 : rlow_q + 32'h1;
      ilow_q <= intrusion_input_oe_n ? 32'h0 : ilow_q + 32'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_run;
    cw |=> scan_run == ($past(host_wdata[0]) && !$past(host_wdata[3]));
  endproperty
  a_run: assert property (p_run) else $error("scan_run wrong");
  property p_gpo;
    cw |-> ##2 general_output == $past(host_wdata[6], 2);
  endproperty
  a_gpo: assert property (p_gpo) else $error("gpo wrong");
  property p_pol;
    !irq_line_oe_n && $stable(pol_q) |-> irq_line_o == pol_q;
  endproperty
  a_pol: assert property (p_pol) else $error("irq polarity");
  property p_ien;
    cfg_wr && !host_wdata[1] |-> ##2 irq_line_oe_n;
  endproperty
  a_ien: assert property (p_ien) else $error("irq not off");
  property p_rel;
    cfg_wr && host_wdata[3] |-> ##2 (irq_line_oe_n && reset_or_overtemp_pin_oe_n);
  endproperty
  a_rel: assert property (p_rel) else $error("pins not released");
  property p_init;
    cfg_wr && host_wdata[7] |-> ##2 (fan_divider == 8'h14 && overtemp_config == 8'h01 && !general_output);
  endproperty
  a_init: assert property (p_init) else $error("restore wrong");
  property p_unm;
    data_rd && (ptr_q > 8'h06 && ptr_q < 8'h20 || ptr_q > 8'h3F) |-> ##2 (host_rvalid && host_rdata == 8'h00);
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_rlow;
    $rose(reset_or_overtemp_pin_oe_n) |-> rlow_q >= PULSE_CYCLES;
  endproperty
  a_rlow: assert property (p_rlow) else $error("reset pulse short");
  property p_ilow;
    $rose(intrusion_input_oe_n) |-> ilow_q >= PULSE_CYCLES;
  endproperty
  a_ilow: assert property (p_ilow) else $error("clear pulse short");
endmodule
bind mcr_bank mcr_bank_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .ptr_wr(ptr_wr),
  .data_wr(data_wr),
  .data_rd(data_rd),
  .host_wdata(host_wdata),
  .host_rdata(host_rdata),
  .host_rvalid(host_rvalid),
  .scan_run(scan_run),
  .fan_divider(fan_divider),
  .overtemp_config(overtemp_config),
  .irq_line_o(irq_line_o),
  .irq_line_oe_n(irq_line_oe_n),
  .reset_or_overtemp_pin_oe_n(reset_or_overtemp_pin_oe_n),
  .intrusion_input_oe_n(intrusion_input_oe_n),
  .general_output(general_output)
);

// [mcr_consts.vh]
/*
 Constants of the monitor configuration register bank: pointer decode,
 power-on values, field positions and pulse timing.
 Assumes inclusion by bare name from the bank's design files.
*/
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Pointer decode
`define MCR_PTR_RESET 8'h00
`define MCR_OFS_CFG 8'h00
`define MCR_OFS_STAT1 8'h01
`define MCR_OFS_STAT2 8'h02
`define MCR_OFS_MASK1 8'h03
`define MCR_OFS_MASK2 8'h04
`define MCR_OFS_FANDIV 8'h05
`define MCR_OFS_OTCFG 8'h06
`define MCR_RAM_FIRST 8'h20
`define MCR_RAM_LAST 8'h3F
`define MCR_RAM_AW 5
`define MCR_RAM_DEPTH 32

////////////////////////////////////////////////////////////////////////////////
// Power-on values
`define MCR_CFG_RESET 8'h08
`define MCR_STAT_RESET 8'h00
`define MCR_MASK_RESET 8'h00
`define MCR_FANDIV_RESET 8'h14
`define MCR_OTCFG_RESET 8'h01
`define MCR_UNMAPPED_READ 8'h00

////////////////////////////////////////////////////////////////////////////////
// Configuration fields
`define MCR_CFG_START 0
`define MCR_CFG_IRQ_EN 1
`define MCR_CFG_IRQ_POL 2
`define MCR_CFG_OUT_REL 3
`define MCR_CFG_RST_PULSE 4
`define MCR_CFG_INTR_CLR 5
`define MCR_CFG_GPO 6
`define MCR_CFG_RESTORE 7

// Fan divisor register: pin function selects
`define MCR_FAN_RST_EN 7
`define MCR_FAN_OS_EN 6

// Status register 2: only bits 5..0 exist
`define MCR_STAT2_USED 8'h3F

////////////////////////////////////////////////////////////////////////////////
// Timing
`define MCR_CLK_HZ 50000000
`define MCR_PULSE_MS 10
`define MCR_PULSE_CYC ((`MCR_PULSE_MS * `MCR_CLK_HZ + 999) / 1000)
`define MCR_TMR_W 20

`endif

// [mcr_host.sv]
/* Host model: one strobe per access.
 Assumes calls from the bench; signals change at falling edges. */
`timescale 1ns/1ps
module mcr_host (
  input wire sys_clk,
  output reg ptr_wr,
  output reg data_wr,
  output reg data_rd,
  output reg [7:0] host_wdata
);
  initial
  begin
    ptr_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // Gap first, so the caller knows the cycle after the strobe
  task automatic op(input logic [1:0] k, input logic [7:0] d, input logic [1:0] gap);
  begin
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    ptr_wr = (k == 2'd0);
    data_wr = (k == 2'd1);
    data_rd = (k == 2'd2);
    host_wdata = d;
    @(negedge sys_clk);
    ptr_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    // Released data never keeps its old value
    host_wdata = ~d;
  end
  endtask
endmodule

// [mcr_pulse_timer.v]
/*
 Fixed-length pulse timer: runs while start is held, ends after CYCLES.
 Assumes start is a level that drops once done is seen; dropping it aborts.
*/
`timescale 1ns/1ps
module mcr_pulse_timer #(
  parameter W = 20,
  parameter CYCLES = 500000
) (
  input wire sys_clk,
  input wire arst_n,
  input wire start,
  output wire active,
  output wire done
);

  reg run_q;
  reg [W-1:0] cnt_q;

  assign active = run_q;
  // Done coincides with the last active cycle so the owner clears start
  assign done = run_q & start & (cnt_q == {{(W-1){1'b0}}, 1'b1});

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_q <= 1'b0;
      cnt_q <= {W{1'b0}};
    end
    else if (!start)
    begin
      run_q <= 1'b0;
      cnt_q <= {W{1'b0}};
    end
    else if (run_q)
    begin
      if (done)
      begin
        run_q <= 1'b0;
      end
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
    else
    begin
      run_q <= 1'b1;
      cnt_q <= CYCLES[W-1:0];
    end
  end

endmodule

// [mcr_value_ram.v]
/*
 Value RAM of the monitor: single port, synchronous write, registered read.
 Assumes the caller decodes the address window and gates the strobes.
*/
`timescale 1ns/1ps
module mcr_value_ram #(
  parameter AW = 5,
  parameter DEPTH = 32
) (
  input wire sys_clk,
  input wire wr_en,
  input wire rd_en,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q
);

  reg [7:0] mem [0:DEPTH-1];

  // No reset on the array: limits are host-written before a scan starts
  always @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wdata;
    end
    if (rd_en)
    begin
      rdata_q <= mem[addr];
    end
  end

endmodule

// [tb_top.sv]
/* Bench of the monitor register bank.
 Assumes mcr_bank, mcr_host and the bound checker. */
`timescale 1ns/1ps
module tb_top;
  localparam PC = 8;
  reg sys_clk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] stat1_set = 8'h00;
  reg [7:0] stat2_set = 8'h00;
  reg overtemp_active = 1'b0;
  reg ci_q = 1'b1;
  wire ptr_wr, data_wr, data_rd, host_rvalid, scan_run, irq_line_o, irq_line_oe_n;
  wire reset_or_overtemp_pin_o, reset_or_overtemp_pin_oe_n, intrusion_input_o, intrusion_input_oe_n;
  wire general_output, intrusion_seen;
  wire intrusion_input_i = ci_q & intrusion_input_oe_n;
  wire [7:0] host_wdata, host_rdata, fan_divider, overtemp_config;
  integer failures = 0;
  integer checks = 0;
  integer i;
  reg [7:0] v;
  reg [7:0] expq[$];
  reg [7:0] ram [0:31];
  reg [31:0] lf = 32'h374F0985;
  logic [7:0] rv [7] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01};
  logic [7:0] um [5] = '{8'h01, 8'h07, 8'h1F, 8'h40, 8'hFF};
  logic [7:0] fv [3] = '{8'h14, 8'h80, 8'h80};
  logic [7:0] cv [3] = '{8'h10, 8'h10, 8'h20};
  mcr_bank #(.PULSE_CYCLES(PC)) dut_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ptr_wr(ptr_wr),
    .data_wr(data_wr),
    .data_rd(data_rd),
    .host_wdata(host_wdata),
    .host_rdata(host_rdata),
    .host_rvalid(host_rvalid),
    .stat1_set(stat1_set),
    .stat2_set(stat2_set),
    .overtemp_active(overtemp_active),
    .scan_run(scan_run),
    .fan_divider(fan_divider),
    .overtemp_config(overtemp_config),
    .irq_line_o(irq_line_o),
    .irq_line_oe_n(irq_line_oe_n),
    .reset_or_overtemp_pin_o(reset_or_overtemp_pin_o),
    .reset_or_overtemp_pin_oe_n(reset_or_overtemp_pin_oe_n),
    .intrusion_input_i(intrusion_input_i),
    .intrusion_input_o(intrusion_input_o),
    .intrusion_input_oe_n(intrusion_input_oe_n),
    .general_output(general_output),
    .intrusion_seen(intrusion_seen)
  );
  mcr_host host_u (
    .sys_clk(sys_clk),
    .ptr_wr(ptr_wr),
    .data_wr(data_wr),
    .data_rd(data_rd),
    .host_wdata(host_wdata)
  );
  // External intrusion latch: pulling its line low resets it
  always @(posedge sys_clk)
    if (!intrusion_input_oe_n)
      ci_q <= 1'b0;
  initial
    forever #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step;
  begin
    lf = lfsr(lf);
  end
  endtask
  task automatic acc(input logic [1:0] k, input logic [7:0] d);
  begin
    step();
    host_u.op(k, d, lf[1:0]);
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    acc(2'd0, a);
    acc(2'd1, d);
  end
  endtask
  task automatic rdp(input logic [7:0] e);
  begin
    expq.push_back(e);
    acc(2'd2, 8'h00);
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
  begin
    acc(2'd0, a);
    rdp(e);
  end
  endtask
  task automatic ev(input logic [7:0] a, input logic [7:0] b);
  begin
    @(negedge sys_clk);
    stat1_set = a;
    stat2_set = b;
    @(negedge sys_clk);
    stat1_set = 8'h00;
    stat2_set = 8'h00;
    repeat (3) @(negedge sys_clk);
  end
  endtask
  task conclude;
  begin
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Read answers come back in request order
  always @(negedge sys_clk)
    if (host_rvalid === 1'b1)
      chk("host_rdata", host_rdata, expq.size() ? expq.pop_front() : 8'hXX);
  initial
  begin
    #400000;
    failures = failures + 1;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    rdp(8'h08);
    rdp(8'h08);
    for (i = 0; i < 7; i++)
      rd(i, rv[i]);
    wr(8'h01, 8'hFF);
    for (i = 0; i < 5; i++)
      rd(um[i], 8'h00);
    for (i = 0; i < 32; i++)
    begin
      step();
      ram[i] = lf[7:0];
      wr(8'h20 + i, ram[i]);
    end
    for (i = 0; i < 36; i++)
    begin
      if (i < 32)
        rd(8'h20 + i, ram[i]);
      else
      begin
        step();
        v = lf[15:8];
        wr(i - 29, v);
        rd(i - 29, v);
      end
    end
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h03);
    ev(8'h01, 8'h00);
    chk("irq_oe_n", irq_line_oe_n, 8'h00);
    chk("irq_o", irq_line_o, 8'h00);
    wr(8'h00, 8'h02);
    repeat (3) @(negedge sys_clk);
    chk("irq_oe_n", irq_line_oe_n, 8'h00);
    rd(8'h01, 8'h01);
    rdp(8'h00);
    repeat (4) @(negedge sys_clk);
    chk("irq_oe_n", irq_line_oe_n, 8'h01);
    wr(8'h00, 8'h07);
    ev(8'h00, 8'h01);
    chk("irq_o", irq_line_o, 8'h01);
    chk("irq_oe_n", irq_line_oe_n, 8'h00);
    wr(8'h00, 8'h0F);
    repeat (3) @(negedge sys_clk);
    chk("irq_oe_n", irq_line_oe_n, 8'h01);
    ev(8'h02, 8'h00);
    wr(8'h00, 8'h07);
    rd(8'h02, 8'h01);
    rd(8'h01, 8'h00);
    chk("scan_run", scan_run, 8'h01);
    ev(8'h04, 8'h00);
    rd(8'h01, 8'h04);
    wr(8'h00, 8'h05);
    ev(8'h08, 8'h00);
    chk("irq_oe_n", irq_line_oe_n, 8'h01);
    rd(8'h01, 8'h08);
    for (i = 0; i < 3; i++)
    begin
      wr(8'h05, fv[i]);
      wr(8'h00, cv[i]);
      repeat (4) @(negedge sys_clk);
      chk("rst_oe_n", reset_or_overtemp_pin_oe_n, i != 1);
      chk("clr_oe_n", intrusion_input_oe_n, i != 2);
      chk("seen", intrusion_seen, i != 2);
      chk("rst_o", reset_or_overtemp_pin_o, 8'h00);
      chk("clr_o", intrusion_input_o, 8'h00);
      chk("fan", fan_divider, fv[i]);
      repeat (PC + 2) @(negedge sys_clk);
      rd(8'h00, 8'h00);
    end
    chk("seen", intrusion_seen, 8'h00);
    // Overtemperature mode held past the pulse length keeps the pulse check quiet
    wr(8'h05, 8'h40);
    overtemp_active = 1'b1;
    repeat (PC + 2) @(negedge sys_clk);
    chk("os_oe_n", reset_or_overtemp_pin_oe_n, 8'h00);
    wr(8'h00, 8'h08);
    overtemp_active = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("os_oe_n", reset_or_overtemp_pin_oe_n, 8'h01);
    wr(8'h03, 8'hA5);
    wr(8'h00, 8'h40);
    repeat (2) @(negedge sys_clk);
    chk("gpo", general_output, 8'h01);
    wr(8'h00, 8'h80);
    for (i = 0; i < 7; i++)
      rd(i, rv[i]);
    repeat (6) @(negedge sys_clk);
    chk("pending", expq.size(), 8'h00);
    conclude();
  end
endmodule
